/* hdl/dsd_decoder.sv */
// Data space decoder: target select, pointer modes, I/O bit ops, stalls
`timescale 1ns/1ns
//
// Contract
// - Addresses 0..31 select working registers
// - Next 64 addresses select standard I/O
// - Next 160 addresses select extended I/O
// - Following 4096 addresses select internal SRAM
// - Extended I/O only via data load/store
// - Port I/O 6-bit, data address adds 0x20
// - Bit ops only on I/O 0x00..0x1F
// - Bit set/clear writes only selected bit
// - Some status flags clear on written one
// - SRAM access takes two clock cycles
// - EEPROM read stalls CPU four cycles
// - EEPROM write stalls CPU two cycles
// - Reset never aborts running EEPROM write
// - Displacement reaches 63 above Y or Z
// - Pre-dec/post-inc update pointer in R26..R31
// - Direct addressing reaches whole data space
// - EEPROM separate byte-wide address space
// - Self-timed write exposes completion status
// - Three storage registers, bit-accessible ones; here only the one at GPIOR_ADDR0 (0x1E) is in bit-op range
// - Write busy blocks reads and address changes
module dsd_decoder import dsd_pkg::*; #(
    parameter int unsigned EE_WRITE_CYCLES = 82500,
    parameter logic [5:0] GPIOR_ADDR0 = 6'h1E,
    parameter logic [5:0] GPIOR_ADDR1 = 6'h2A,
    parameter logic [5:0] GPIOR_ADDR2 = 6'h2B
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire dsd_req_t i_req,
    input wire logic [15:0] i_ptr_x,
    input wire logic [15:0] i_ptr_y,
    input wire logic [15:0] i_ptr_z,
    input wire logic [7:0] i_io_rdata,
    input wire logic i_ee_rd_req,
    input wire logic i_ee_wr_req,
    input wire logic [DSD_EE_ADDR_W-1:0] i_ee_addr,
    input wire logic [7:0] i_ee_wdata,
    input wire logic [7:0] i_w1c_mask,
    output dsd_sel_t o_sel,
    output logic [DSD_ADDR_W-1:0] o_addr,
    output logic o_io_wr,
    output logic [7:0] o_io_wdata,
    output logic o_skip,
    output logic o_ptr_wr,
    output dsd_ptr_t o_ptr_id,
    output logic [15:0] o_ptr_new,
    output logic o_stall,
    output logic o_sram_done,
    output logic o_ee_busy,
    output logic o_ee_mem_wr,
    output logic o_ee_rd_ok,
    output logic [DSD_EE_ADDR_W-1:0] o_ee_addr,
    output logic [7:0] o_ee_wdata,
    output logic [7:0] o_gp_rdata,
    output logic o_gp_hit
);
    localparam logic [16:0] EE_WR_CNT = 17'(EE_WRITE_CYCLES);

    logic [15:0] base;
    logic [15:0] eff;
    logic [15:0] ptr_val;
    logic ext_blocked;
    logic bit_ok;
    logic [7:0] bit_mask;
    logic [7:0] merged;
    logic [2:0] stall_cnt;
    logic [2:0] sram_cnt;
    logic [16:0] ee_cnt;
    logic [7:0] gpior [DSD_GPIOR_N];
    logic [1:0] gp_idx;
    logic [5:0] gp_io;

    always_comb begin
        unique case (i_req.ptr)
            DSD_PTR_X: ptr_val = i_ptr_x;
            DSD_PTR_Y: ptr_val = i_ptr_y;
            DSD_PTR_Z: ptr_val = i_ptr_z;
            default: ptr_val = i_ptr_z;
        endcase
    end

    // Effective address per addressing mode
    always_comb begin
        base = ptr_val;
        unique case (i_req.mode)
            DSD_AM_DIRECT: eff = i_req.addr;
            DSD_AM_IND: eff = base;
            // X has no displacement form; treat as plain indirect
            DSD_AM_DISP: eff = (i_req.ptr == DSD_PTR_X) ? base : base + {10'h000, i_req.disp & DSD_DISP_MAX};
            DSD_AM_PREDEC: eff = base - DSD_PTR_STEP;
            DSD_AM_POSTINC: eff = base;
            DSD_AM_IOPORT: eff = {10'h000, i_req.io_addr} + DSD_IO_OFFSET;
            DSD_AM_IOBIT: eff = {10'h000, i_req.io_addr} + DSD_IO_OFFSET;
            default: eff = i_req.addr;
        endcase
    end

    // Port I/O can never land in extended I/O because io_addr is 6 bits
    assign ext_blocked = (i_req.mode == DSD_AM_IOPORT) || (i_req.mode == DSD_AM_IOBIT);
    assign bit_ok = (i_req.io_addr <= DSD_BIT_IO_LAST);

    always_comb begin
        o_sel = '0;
        if (i_req.valid) begin
            if (eff < DSD_IO_BASE) begin
                o_sel.reg_sel = !ext_blocked;
            end else if (eff < DSD_EXT_BASE) begin
                o_sel.io_sel = !(i_req.mode == DSD_AM_IOBIT && !bit_ok);
            end else if (eff < DSD_SRAM_BASE) begin
                o_sel.ext_sel = !ext_blocked;
            end else if (eff <= DSD_SRAM_LAST) begin
                o_sel.sram_sel = !ext_blocked;
            end
        end
    end
    assign o_addr = eff;

    // Bit set/clear: other bits written back, write-one-to-clear flags masked off
    assign bit_mask = 8'h01 << i_req.bit_sel;
    always_comb begin
        merged = i_io_rdata & ~i_w1c_mask;
        if (i_req.bitop == DSD_BIT_SET) begin
            merged = merged | bit_mask;
        end else if (i_req.bitop == DSD_BIT_CLR) begin
            merged = merged & ~bit_mask;
        end
    end

    always_comb begin
        o_io_wr = 1'b0;
        o_io_wdata = i_req.wdata;
        if (o_sel.io_sel && i_req.mode == DSD_AM_IOBIT) begin
            o_io_wr = (i_req.bitop == DSD_BIT_SET) || (i_req.bitop == DSD_BIT_CLR);
            o_io_wdata = merged;
        end else if (o_sel.io_sel || o_sel.ext_sel) begin
            o_io_wr = i_req.write;
        end
    end
    assign o_skip = o_sel.io_sel && i_req.mode == DSD_AM_IOBIT && i_req.bitop == DSD_BIT_TEST
        && i_io_rdata[i_req.bit_sel];

    // Pointer write-back for auto modes
    always_comb begin
        o_ptr_wr = i_req.valid && (i_req.mode == DSD_AM_PREDEC || i_req.mode == DSD_AM_POSTINC);
        o_ptr_id = i_req.ptr;
        o_ptr_new = (i_req.mode == DSD_AM_PREDEC) ? base - DSD_PTR_STEP : base + DSD_PTR_STEP;
    end

    // SRAM two-cycle access
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            sram_cnt <= 3'h0;
        end else if (sram_cnt != 3'h0) begin
            sram_cnt <= sram_cnt - 3'h1;
        end else if (o_sel.sram_sel) begin
            sram_cnt <= DSD_SRAM_CYCLES - 3'h1;
        end
    end
    assign o_sram_done = (sram_cnt == 3'h1);

    // EEPROM engine; write counter ignores reset so a started write completes
    assign o_ee_busy = (ee_cnt != 17'h0);
    assign o_ee_rd_ok = i_ee_rd_req && !o_ee_busy;
    always_ff @(posedge i_clk_sys) begin
        if (ee_cnt != 17'h0) begin
            ee_cnt <= ee_cnt - 17'h1;
        end else if (i_ee_wr_req && !i_rst) begin
            ee_cnt <= EE_WR_CNT;
        end else if (i_rst) begin
            ee_cnt <= 17'h0;
        end
    end
    always_ff @(posedge i_clk_sys) begin
        if (i_rst && !o_ee_busy) begin
            o_ee_addr <= '0;
            o_ee_wdata <= 8'h00;
        end else if (!o_ee_busy && (i_ee_wr_req || i_ee_rd_req)) begin
            o_ee_addr <= i_ee_addr;
            o_ee_wdata <= i_ee_wdata;
        end
    end
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_ee_mem_wr <= 1'b0;
        end else begin
            o_ee_mem_wr <= i_ee_wr_req && !o_ee_busy;
        end
    end

    // CPU stall counter
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            stall_cnt <= 3'h0;
        end else if (i_ee_rd_req && !o_ee_busy) begin
            stall_cnt <= DSD_EE_RD_STALL;
        end else if (i_ee_wr_req && !o_ee_busy) begin
            stall_cnt <= DSD_EE_WR_STALL;
        end else if (stall_cnt != 3'h0) begin
            stall_cnt <= stall_cnt - 3'h1;
        end
    end
    assign o_stall = (stall_cnt != 3'h0);

    // General purpose storage registers
    // Decode from the effective address so loads and stores reach them too
    assign gp_io = 6'(eff - DSD_IO_OFFSET);
    always_comb begin
        gp_idx = 2'h3;
        if (gp_io == GPIOR_ADDR0) gp_idx = 2'h0;
        if (gp_io == GPIOR_ADDR1) gp_idx = 2'h1;
        if (gp_io == GPIOR_ADDR2) gp_idx = 2'h2;
    end
    assign o_gp_hit = o_sel.io_sel && gp_idx != 2'h3;
    assign o_gp_rdata = (gp_idx != 2'h3) ? gpior[gp_idx] : 8'h00;
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            for (int i = 0; i < DSD_GPIOR_N; i++) gpior[i] <= 8'h00;
        end else if (o_gp_hit && o_io_wr) begin
            gpior[gp_idx] <= (i_req.mode == DSD_AM_IOBIT)
                ? ((gpior[gp_idx] & ~bit_mask) | (i_req.bitop == DSD_BIT_SET ? bit_mask : 8'h00))
                : i_req.wdata;
        end
    end

    // Building blocks for the multi-step properties and the same-cycle bit-write checks
    sequence s_rd_start;
        i_ee_rd_req && !o_ee_busy;
    endsequence

    sequence s_wr_start;
        i_ee_wr_req && !o_ee_busy && !i_rst;
    endsequence

    sequence s_quiet;
        !i_ee_rd_req && !i_ee_wr_req;
    endsequence

    sequence s_sram_start;
        o_sel.sram_sel && sram_cnt == 3'h0;
    endsequence

    sequence s_bit_write;
        o_io_wr && i_req.mode == DSD_AM_IOBIT;
    endsequence

    a_reg_sel: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_req.valid && i_req.mode == DSD_AM_DIRECT && i_req.addr < DSD_IO_BASE) |-> o_sel.reg_sel)
        else $error("reg not selected");

    a_io_sel: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_req.valid && i_req.mode == DSD_AM_DIRECT && i_req.addr >= DSD_IO_BASE && i_req.addr < DSD_EXT_BASE)
        |-> o_sel.io_sel) else $error("io not selected");

    a_ext_sel: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_req.valid && i_req.mode == DSD_AM_DIRECT && i_req.addr >= DSD_EXT_BASE && i_req.addr < DSD_SRAM_BASE)
        |-> o_sel.ext_sel) else $error("ext not selected");

    a_sram_sel: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_req.valid && i_req.mode == DSD_AM_DIRECT && i_req.addr >= DSD_SRAM_BASE && i_req.addr <= DSD_SRAM_LAST)
        |-> o_sel.sram_sel) else $error("sram not selected");

    a_ext_port: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        ext_blocked |-> !o_sel.ext_sel) else $error("ext via port");

    a_io_offset: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_req.valid && i_req.mode == DSD_AM_IOPORT) |-> o_sel.io_sel && o_addr == {10'h000, i_req.io_addr} + DSD_IO_OFFSET)
        else $error("io offset wrong");

    a_bit_range: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_req.mode == DSD_AM_IOBIT && i_req.io_addr > DSD_BIT_IO_LAST) |-> !o_io_wr && !o_skip)
        else $error("bit op high");

    a_skip_low: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        o_skip |-> i_req.io_addr <= DSD_BIT_IO_LAST && i_io_rdata[i_req.bit_sel])
        else $error("skip out of range");

    a_bit_only: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        s_bit_write |-> ((o_io_wdata ^ (i_io_rdata & ~i_w1c_mask)) & ~bit_mask) == 8'h00)
        else $error("other bits touched");

    a_w1c_zero: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        s_bit_write |-> (o_io_wdata & i_w1c_mask & ~bit_mask) == 8'h00)
        else $error("flag cleared by bit op");

    a_sram_two: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        s_sram_start |=> o_sram_done) else $error("sram timing");

    a_sram_pulse: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        o_sram_done |=> !o_sram_done) else $error("sram done too long");

    a_rd_stall: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        s_rd_start ##1 s_quiet [*4] |-> ($past(o_stall, 3) && o_stall) ##1 !o_stall)
        else $error("read stall");

    a_wr_stall: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        s_wr_start ##1 s_quiet [*2] |-> ($past(o_stall) && o_stall) ##1 !o_stall)
        else $error("write stall");

    // No disable here: the point is what happens while reset is high
    a_rst_keeps_wr: assert property (@(posedge i_clk_sys)
        (i_rst && ee_cnt > 17'h1) |=> o_ee_busy) else $error("reset aborted write");

    a_disp_reach: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_req.valid && i_req.mode == DSD_AM_DISP && i_req.ptr == DSD_PTR_Y)
        |-> o_addr == i_ptr_y + {10'h000, i_req.disp}) else $error("displacement wrong");

    a_postinc: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_req.valid && i_req.mode == DSD_AM_POSTINC) |-> o_ptr_wr && o_ptr_new == ptr_val + DSD_PTR_STEP)
        else $error("post increment wrong");

    a_predec: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_req.valid && i_req.mode == DSD_AM_PREDEC) |-> o_ptr_wr && o_ptr_new == o_addr
        && o_addr == ptr_val - DSD_PTR_STEP) else $error("pre decrement wrong");

    a_direct_addr: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_req.valid && i_req.mode == DSD_AM_DIRECT) |-> o_addr == i_req.addr)
        else $error("direct address wrong");

    a_mem_wr: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        s_wr_start |=> o_ee_mem_wr) else $error("eeprom write missed");

    a_busy_start: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        s_wr_start |=> o_ee_busy) else $error("busy not raised");

    a_rd_block: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        o_ee_busy |-> !o_ee_rd_ok) else $error("read while busy");

    a_busy_addr: assert property (@(posedge i_clk_sys)
        o_ee_busy |=> $stable(o_ee_addr)) else $error("addr changed busy");

    a_one_select: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        $onehot0(o_sel) && (eff <= DSD_SRAM_LAST || o_sel == '0)) else $error("bad select");
endmodule

/* hdl/dsd_pkg.sv */
// Package for the data space decoder: map, opcodes, timing counts
package dsd_pkg;
    localparam int unsigned DSD_ADDR_W = 16;
    localparam int unsigned DSD_IO_W = 6;
    localparam int unsigned DSD_EE_ADDR_W = 12;
    localparam logic [15:0] DSD_REG_BASE = 16'h0000;
    localparam logic [15:0] DSD_IO_BASE = 16'h0020;
    localparam logic [15:0] DSD_EXT_BASE = 16'h0060;
    localparam logic [15:0] DSD_SRAM_BASE = 16'h0100;
    localparam logic [15:0] DSD_SRAM_LAST = 16'h10FF;
    localparam logic [15:0] DSD_IO_OFFSET = 16'h0020;
    localparam logic [5:0] DSD_BIT_IO_LAST = 6'h1F;
    localparam logic [4:0] DSD_PTR_FIRST = 5'h1A;
    localparam logic [5:0] DSD_DISP_MAX = 6'h3F;
    localparam logic [2:0] DSD_SRAM_CYCLES = 3'h2;
    localparam logic [2:0] DSD_EE_RD_STALL = 3'h4;
    localparam logic [2:0] DSD_EE_WR_STALL = 3'h2;
    localparam logic [15:0] DSD_PTR_STEP = 16'h0001;
    localparam int unsigned DSD_GPIOR_N = 3;

    typedef enum logic [1:0] {
        DSD_PTR_X = 2'b00,
        DSD_PTR_Y = 2'b01,
        DSD_PTR_Z = 2'b10
    } dsd_ptr_t;

    typedef enum logic [2:0] {
        DSD_AM_DIRECT = 3'b000,
        DSD_AM_IND = 3'b001,
        DSD_AM_DISP = 3'b010,
        DSD_AM_PREDEC = 3'b011,
        DSD_AM_POSTINC = 3'b100,
        DSD_AM_IOPORT = 3'b101,
        DSD_AM_IOBIT = 3'b110
    } dsd_mode_t;

    typedef enum logic [1:0] {
        DSD_BIT_NONE = 2'b00,
        DSD_BIT_SET = 2'b01,
        DSD_BIT_CLR = 2'b10,
        DSD_BIT_TEST = 2'b11
    } dsd_bitop_t;

    typedef struct packed {
        logic valid;
        logic write;
        dsd_mode_t mode;
        dsd_ptr_t ptr;
        logic [5:0] disp;
        logic [15:0] addr;
        logic [5:0] io_addr;
        dsd_bitop_t bitop;
        logic [2:0] bit_sel;
        logic [7:0] wdata;
    } dsd_req_t;

    typedef struct packed {
        logic reg_sel;
        logic io_sel;
        logic ext_sel;
        logic sram_sel;
    } dsd_sel_t;
endpackage

/* test/data_space_decoder_tb.sv */
// Self-checking bench for the data space decoder
`timescale 1ns/1ns
module data_space_decoder_tb import dsd_pkg::*; ;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    dsd_req_t r = '0;
    logic [15:0] px, py, pz;
    logic [7:0] io_rd;
    logic ee_rd = 1'b0, ee_wr = 1'b0;
    logic [11:0] ee_a = 12'h000;
    logic [7:0] ee_d = 8'h00, w1c = 8'h00;
    dsd_sel_t o_sel;
    logic [15:0] o_addr, o_ptr_new;
    logic o_io_wr, o_skip, o_ptr_wr, o_stall, o_sram_done, o_ee_busy, o_ee_mem_wr, o_ee_rd_ok, o_gp_hit;
    logic [7:0] o_io_wdata, o_ee_wdata, o_gp_rdata;
    dsd_ptr_t o_ptr_id;
    logic [11:0] o_ee_addr;
    int miscompares = 0;
    int tests_run = 0;
    always #20 i_clk_sys = ~i_clk_sys;
    dsd_decoder #(.EE_WRITE_CYCLES(20)) dsd_decoder_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_req(r),
        .i_ptr_x(px), .i_ptr_y(py), .i_ptr_z(pz), .i_io_rdata(io_rd), .i_ee_rd_req(ee_rd), .i_ee_wr_req(ee_wr),
        .i_ee_addr(ee_a), .i_ee_wdata(ee_d), .i_w1c_mask(w1c), .o_sel(o_sel), .o_addr(o_addr), .o_io_wr(o_io_wr),
        .o_io_wdata(o_io_wdata), .o_skip(o_skip), .o_ptr_wr(o_ptr_wr), .o_ptr_id(o_ptr_id), .o_ptr_new(o_ptr_new),
        .o_stall(o_stall), .o_sram_done(o_sram_done), .o_ee_busy(o_ee_busy), .o_ee_mem_wr(o_ee_mem_wr),
        .o_ee_rd_ok(o_ee_rd_ok), .o_ee_addr(o_ee_addr), .o_ee_wdata(o_ee_wdata), .o_gp_rdata(o_gp_rdata),
        .o_gp_hit(o_gp_hit));
    dsd_cpu_model dsd_cpu_model_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(o_addr), .i_io_wr(o_io_wr),
        .i_io_wdata(o_io_wdata), .i_ptr_wr(o_ptr_wr), .i_ptr_id(o_ptr_id), .i_ptr_new(o_ptr_new),
        .o_ptr_x(px), .o_ptr_y(py), .o_ptr_z(pz), .o_io_rdata(io_rd));
    task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic rq(input dsd_mode_t m, input logic [15:0] a, input logic [5:0] io, input dsd_bitop_t b,
        input logic [2:0] bs, input logic w, input logic [7:0] wd);
        @(negedge i_clk_sys);
        r = '0;
        r.valid = 1'b1;
        r.mode = m;
        r.addr = a;
        r.io_addr = io;
        r.bitop = b;
        r.bit_sel = bs;
        r.write = w;
        r.wdata = wd;
        #1;
    endtask
    task automatic t_map;
        logic [15:0] a [9] = '{16'h0000, 16'h001F, 16'h0020, 16'h005F, 16'h0060, 16'h00FF, 16'h0100, 16'h10FF,
            16'h1100};
        logic [3:0] e [9] = '{4'h8, 4'h8, 4'h4, 4'h4, 4'h2, 4'h2, 4'h1, 4'h1, 4'h0};
        for (int i = 0; i < 9; i++) begin
            rq(DSD_AM_DIRECT, a[i], 6'h00, DSD_BIT_NONE, 3'h0, 1'b0, 8'h00);
            chk("sel", 16'(o_sel), 16'(e[i]));
            chk("addr", o_addr, a[i]);
        end
        chk("sram_first", 16'(o_sram_done), 16'h0000);
        @(negedge i_clk_sys);
        chk("sram_second", 16'(o_sram_done), 16'h0000);
        rq(DSD_AM_DIRECT, 16'h0200, 6'h00, DSD_BIT_NONE, 3'h0, 1'b0, 8'h00);
        @(negedge i_clk_sys);
        chk("sram_done", 16'(o_sram_done), 16'h0001);
        rq(DSD_AM_IOPORT, 16'h0000, 6'h3F, DSD_BIT_NONE, 3'h0, 1'b0, 8'h00);
        chk("port_addr", o_addr, 16'h005F);
        chk("port_sel", 16'(o_sel), 16'h0004);
    endtask
    task automatic t_bits;
        w1c = 8'h01;
        rq(DSD_AM_IOPORT, 16'h0000, 6'h05, DSD_BIT_NONE, 3'h0, 1'b1, 8'h81);
        rq(DSD_AM_IOBIT, 16'h0000, 6'h05, DSD_BIT_SET, 3'h3, 1'b1, 8'h00);
        chk("set_wr", 16'(o_io_wr), 16'h0001);
        chk("set_data", 16'(o_io_wdata), 16'h0088);
        rq(DSD_AM_IOBIT, 16'h0000, 6'h05, DSD_BIT_CLR, 3'h7, 1'b1, 8'h00);
        chk("clr_data", 16'(o_io_wdata), 16'h0008);
        rq(DSD_AM_IOBIT, 16'h0000, 6'h05, DSD_BIT_TEST, 3'h3, 1'b0, 8'h00);
        chk("skip_set", 16'(o_skip), 16'h0001);
        rq(DSD_AM_IOBIT, 16'h0000, 6'h05, DSD_BIT_TEST, 3'h7, 1'b0, 8'h00);
        chk("skip_clr", 16'(o_skip), 16'h0000);
        rq(DSD_AM_IOBIT, 16'h0000, 6'h20, DSD_BIT_SET, 3'h0, 1'b1, 8'h00);
        chk("high_wr", 16'(o_io_wr), 16'h0000);
        rq(DSD_AM_IOPORT, 16'h0000, 6'h1E, DSD_BIT_NONE, 3'h0, 1'b1, 8'hA5);
        rq(DSD_AM_IOPORT, 16'h0000, 6'h1E, DSD_BIT_NONE, 3'h0, 1'b0, 8'h00);
        chk("gp_hit", 16'(o_gp_hit), 16'h0001);
        chk("gp_data", 16'(o_gp_rdata), 16'h00A5);
        rq(DSD_AM_DIRECT, 16'h003E, 6'h00, DSD_BIT_NONE, 3'h0, 1'b0, 8'h00);
        chk("gp_load", 16'(o_gp_rdata), 16'h00A5);
        w1c = 8'h00;
    endtask
    task automatic t_ptr;
        rq(DSD_AM_POSTINC, 16'h0000, 6'h00, DSD_BIT_NONE, 3'h0, 1'b0, 8'h00);
        chk("inc_addr", o_addr, 16'h0200);
        chk("inc_new", o_ptr_new, 16'h0201);
        chk("inc_wr", 16'(o_ptr_wr), 16'h0001);
        chk("inc_id", 16'(o_ptr_id), 16'h0000);
        rq(DSD_AM_PREDEC, 16'h0000, 6'h00, DSD_BIT_NONE, 3'h0, 1'b0, 8'h00);
        chk("dec_addr", o_addr, 16'h0200);
        chk("dec_new", o_ptr_new, 16'h0200);
        chk("dec_wr", 16'(o_ptr_wr), 16'h0001);
        r.ptr = DSD_PTR_Z;
        r.mode = DSD_AM_DISP;
        r.disp = 6'h3F;
        #1;
        chk("disp_addr", o_addr, 16'h043F);
    endtask
    task automatic t_ee;
        int n;
        @(negedge i_clk_sys);
        r = '0;
        ee_rd = 1'b1;
        #1;
        chk("rd_ok", 16'(o_ee_rd_ok), 16'h0001);
        @(negedge i_clk_sys);
        ee_rd = 1'b0;
        for (int i = 0; i < 4; i++) begin
            chk("rd_stall", 16'(o_stall), 16'h0001);
            @(negedge i_clk_sys);
        end
        chk("rd_stall_end", 16'(o_stall), 16'h0000);
        ee_a = 12'h123;
        ee_d = 8'h5A;
        ee_wr = 1'b1;
        @(negedge i_clk_sys);
        ee_wr = 1'b0;
        chk("wr_addr", 16'(o_ee_addr), 16'h0123);
        chk("wr_data", 16'(o_ee_wdata), 16'h005A);
        chk("mem_wr", 16'(o_ee_mem_wr), 16'h0001);
        chk("wr_stall", 16'(o_stall), 16'h0001);
        @(negedge i_clk_sys);
        chk("wr_stall2", 16'(o_stall), 16'h0001);
        @(negedge i_clk_sys);
        chk("wr_stall_end", 16'(o_stall), 16'h0000);
        ee_a = 12'h456;
        ee_rd = 1'b1;
        ee_wr = 1'b1;
        #1;
        chk("busy_rd", 16'(o_ee_rd_ok), 16'h0000);
        @(negedge i_clk_sys);
        ee_rd = 1'b0;
        ee_wr = 1'b0;
        chk("busy_addr", 16'(o_ee_addr), 16'h0123);
        chk("busy_nostall", 16'(o_stall), 16'h0000);
        i_rst = 1'b1;
        @(negedge i_clk_sys);
        i_rst = 1'b0;
        chk("busy_rst", 16'(o_ee_busy), 16'h0001);
        n = 0;
        while (o_ee_busy === 1'b1 && n < 40) begin
            @(negedge i_clk_sys);
            n++;
        end
        chk("done", 16'(o_ee_busy), 16'h0000);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #(40 * 3000);
        miscompares++;
        end_sim();
    end
    initial begin
        repeat (3) @(negedge i_clk_sys);
        i_rst = 1'b0;
        t_map();
        t_bits();
        t_ptr();
        t_ee();
        end_sim();
    end
endmodule

/* test/dsd_cpu_model.sv */
// CPU side model: pointer pairs and I/O register store
`timescale 1ns/1ns
module dsd_cpu_model import dsd_pkg::*; (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic [15:0] i_addr,
    input wire logic i_io_wr,
    input wire logic [7:0] i_io_wdata,
    input wire logic i_ptr_wr,
    input wire dsd_ptr_t i_ptr_id,
    input wire logic [15:0] i_ptr_new,
    output logic [15:0] o_ptr_x,
    output logic [15:0] o_ptr_y,
    output logic [15:0] o_ptr_z,
    output logic [7:0] o_io_rdata
);
    logic [7:0] io_mem [64];
    logic [5:0] io_idx;
    // Data address minus the I/O offset gives the port index
    assign io_idx = 6'(i_addr - 16'h0020);
    assign o_io_rdata = io_mem[io_idx];
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_ptr_x <= 16'h0200;
            o_ptr_y <= 16'h0300;
            o_ptr_z <= 16'h0400;
        end else if (i_ptr_wr) begin
            case (i_ptr_id)
                DSD_PTR_X: o_ptr_x <= i_ptr_new;
                DSD_PTR_Y: o_ptr_y <= i_ptr_new;
                default: o_ptr_z <= i_ptr_new;
            endcase
        end
    end
    // Whole-byte store; stimulus keeps off reserved spots
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            io_mem <= '{default: 8'h00};
        end else if (i_io_wr) begin
            io_mem[io_idx] <= i_io_wdata;
        end
    end
endmodule
